/* File: hbsh_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef HBSH_DEFS_SVH
`define HBSH_DEFS_SVH
`define HBSH_A_TXS0 8'h00
`define HBSH_A_TXS1 8'h04
`define HBSH_A_RXS0 8'h08
`define HBSH_A_RXS1 8'h0C
`define HBSH_A_CTRL 8'h10
`define HBSH_A_SERR 8'h14
`define HBSH_A_IST 8'h18
`define HBSH_A_ICLR 8'h1C
`define HBSH_A_IEN 8'h20
`define HBSH_A_TXD 4'h4
`define HBSH_A_RXD 4'h5
`define HBSH_CNT_MAX 4'h8
`define HBSH_B_TX_SOF 4
`define HBSH_B_TX_EOF 5
`define HBSH_B_TX_ABT 6
`define HBSH_B_RX_SOF 6
`define HBSH_B_RX_EOF 7
`define HBSH_ERR_NONE 2'h0
`define HBSH_ERR_CRC 2'h1
`define HBSH_ERR_ALIGN 2'h2
`define HBSH_ERR_ABORT 2'h3
`define HBSH_C_HDLC 0
`define HBSH_C_FSK 1
`define HBSH_E_TX 0
`define HBSH_E_RX 1
`define HBSH_E_OVR 2
`define HBSH_I_TX 0
`define HBSH_I_RX 1
`define HBSH_RST_STAT 8'h00
`define HBSH_RST_CTRL 4'h0
`define HBSH_CLK_HZ 25000000
`define HBSH_BAUD_FAST 1200
`define HBSH_BAUD_MID 300
`define HBSH_BAUD_SLOW 75
`define HBSH_CYC_FAST (`HBSH_CLK_HZ / `HBSH_BAUD_FAST)
`define HBSH_CYC_MID (`HBSH_CLK_HZ / `HBSH_BAUD_MID)
`define HBSH_CYC_SLOW (`HBSH_CLK_HZ / `HBSH_BAUD_SLOW)
`endif

/* File: hbsh_pkg.sv */
// shared types of the buffer status handshake block
package hbsh_pkg;
   typedef struct packed {
      logic [7:0] data;
      logic sof;
      logic eof;
      logic abort;
   } hbsh_txb_s;
   typedef struct packed {
      logic [7:0] data;
      logic first;
      logic last;
      logic [1:0] err;
   } hbsh_rxb_s;
   typedef enum logic [1:0] {BAUD_FAST, BAUD_MID, BAUD_SLOW} hbsh_baud_e;
   typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_ABORT} hbsh_txst_e;
   typedef enum logic [1:0] {SM_IDLE, SM_DATA, SM_STOP} hbsh_smst_e;
endpackage

/* File: hbsh_framer.sv */
// transmit framer: drains one buffer into the byte stream
`timescale 1ns/1ps
`include "hbsh_defs.svh"
module hbsh_framer (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // buffer side
   input wire logic start_i,
   input wire logic hdlc_i,
   input wire logic [7:0] stat_i,
   input wire logic [7:0] byte_i,
   output logic [2:0] idx_o,
   output logic busy_o,
   output logic done_o,
   // stream side
   output hbsh_pkg::hbsh_txb_s out_o,
   output logic vld_o,
   input wire logic rdy_i
);
   hbsh_pkg::hbsh_txst_e st_ff;
   logic [3:0] idx_ff;
   logic [3:0] cnt;
   assign cnt = stat_i[3:0];
   assign idx_o = idx_ff[2:0];
   assign busy_o = (st_ff != hbsh_pkg::TX_IDLE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= hbsh_pkg::TX_IDLE;
         idx_ff <= 4'h0;
         vld_o <= 1'b0;
         done_o <= 1'b0;
         out_o <= '0;
      end else begin
         done_o <= 1'b0;
         case (st_ff)
            hbsh_pkg::TX_IDLE: if (start_i) begin
               idx_ff <= 4'h0;
               if (hdlc_i && stat_i[`HBSH_B_TX_ABT]) begin
                  out_o <= '{data: 8'h00, sof: 1'b0, eof: 1'b0, abort: 1'b1};
                  vld_o <= 1'b1;
                  st_ff <= hbsh_pkg::TX_ABORT;
               end else begin
                  st_ff <= hbsh_pkg::TX_SEND;
               end
            end
            hbsh_pkg::TX_SEND: if (!vld_o || rdy_i) begin
               if (idx_ff < cnt) begin
                  out_o.data <= byte_i;
                  out_o.sof <= hdlc_i && stat_i[`HBSH_B_TX_SOF] && idx_ff == 4'h0;
                  out_o.eof <= hdlc_i && stat_i[`HBSH_B_TX_EOF]
                     && idx_ff == cnt - 4'h1;
                  out_o.abort <= 1'b0;
                  vld_o <= 1'b1;
                  idx_ff <= idx_ff + 4'h1;
               end else begin
                  vld_o <= 1'b0;
                  done_o <= 1'b1;
                  st_ff <= hbsh_pkg::TX_IDLE;
               end
            end
            hbsh_pkg::TX_ABORT: if (rdy_i) begin
               vld_o <= 1'b0;
               done_o <= 1'b1;
               st_ff <= hbsh_pkg::TX_IDLE;
            end
            default: st_ff <= hbsh_pkg::TX_IDLE;
         endcase
      end
   end
endmodule

/* File: hbsh_sampler.sv */
// serial receive sampler: recovers bytes at the selected baud rate
`timescale 1ns/1ps
`include "hbsh_defs.svh"
module hbsh_sampler #(
   parameter int CYC_FAST = `HBSH_CYC_FAST,
   parameter int CYC_MID = `HBSH_CYC_MID,
   parameter int CYC_SLOW = `HBSH_CYC_SLOW
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic en_i,
   input wire hbsh_pkg::hbsh_baud_e baud_i,
   // line and bytes
   input wire logic bit_i,
   output logic [7:0] byte_o,
   output logic vld_o
);
   hbsh_pkg::hbsh_smst_e st_ff;
   logic sync1_ff;
   logic sync2_ff;
   logic [19:0] cnt_ff;
   logic [19:0] per;
   logic [2:0] nbit_ff;
   logic [7:0] sh_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
      end else begin
         sync1_ff <= bit_i;
         sync2_ff <= sync1_ff;
      end
   end

   always_comb begin
      case (baud_i)
         hbsh_pkg::BAUD_FAST: per = 20'(CYC_FAST);
         hbsh_pkg::BAUD_MID: per = 20'(CYC_MID);
         default: per = 20'(CYC_SLOW);
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         st_ff <= hbsh_pkg::SM_IDLE;
         cnt_ff <= 20'h0;
         nbit_ff <= 3'h0;
         sh_ff <= 8'h00;
         byte_o <= 8'h00;
         vld_o <= 1'b0;
      end else begin
         vld_o <= 1'b0;
         case (st_ff)
            hbsh_pkg::SM_IDLE: if (!sync2_ff) begin
               // skip the start bit and land mid first data bit
               cnt_ff <= per + {1'b0, per[19:1]};
               nbit_ff <= 3'h0;
               st_ff <= hbsh_pkg::SM_DATA;
            end
            hbsh_pkg::SM_DATA: if (cnt_ff == 20'h0) begin
               sh_ff <= {sync2_ff, sh_ff[7:1]};
               cnt_ff <= per - 20'h1;
               nbit_ff <= nbit_ff + 3'h1;
               if (nbit_ff == 3'h7) begin
                  st_ff <= hbsh_pkg::SM_STOP;
               end
            end else begin
               cnt_ff <= cnt_ff - 20'h1;
            end
            hbsh_pkg::SM_STOP: if (cnt_ff == 20'h0) begin
               byte_o <= sh_ff;
               vld_o <= 1'b1;
               st_ff <= hbsh_pkg::SM_IDLE;
            end else begin
               cnt_ff <= cnt_ff - 20'h1;
            end
            default: st_ff <= hbsh_pkg::SM_IDLE;
         endcase
      end
   end

   a_bit_period: assert property (@(posedge clk_i) disable iff (rst_i)
      (en_i && st_ff == hbsh_pkg::SM_DATA && cnt_ff == 20'h0)
      |=> (cnt_ff == $past(per) - 20'h1))
      else $error("bit sample spacing is not one baud period");
endmodule

/* File: hbsh_top.sv */
// buffer status handshake block: bus registers, buffers and exchange
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "hbsh_defs.svh"
module hbsh_top #(
   parameter int CYC_FAST = `HBSH_CYC_FAST,
   parameter int CYC_MID = `HBSH_CYC_MID,
   parameter int CYC_SLOW = `HBSH_CYC_SLOW
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // transmit byte stream
   output hbsh_pkg::hbsh_txb_s tx_o,
   output logic tx_vld_o,
   input wire logic tx_rdy_i,
   // receive byte stream and serial line
   input wire hbsh_pkg::hbsh_rxb_s rx_i,
   input wire logic rx_vld_i,
   input wire logic rx_bit_i,
   // interrupt
   output logic irq_o
);
   logic ph_ff;
   logic ph_wr_ff;
   logic ph_hit_ff;
   logic [7:0] ph_addr_ff;
   logic wr;
   logic [31:0] rd_val;
   logic [7:0] txs_ff [2];
   logic [7:0] rxs_ff [2];
   logic [7:0] txd_ff [16];
   logic [7:0] rxd_ff [16];
   logic [3:0] ctrl_ff;
   logic tx_act_ff;
   logic [2:0] serr_ff;
   logic [1:0] ist_ff;
   logic [1:0] ien_ff;
   logic [1:0] tx_bad;
   logic [1:0] rx_bad;
   logic tx_sel_ff;
   logic tx_start;
   logic tx_busy;
   logic tx_done;
   logic [2:0] tx_idx;
   logic rx_sel_ff;
   logic rx_fill_ff;
   logic rx_sof_ff;
   logic [3:0] rx_cnt_ff;
   logic [3:0] rx_n;
   logic rx_start;
   logic rx_ovr;
   logic rx_take;
   logic rx_cmp;
   logic [7:0] rx_stat_new;
   logic [7:0] sm_byte;
   logic sm_vld;
   hbsh_pkg::hbsh_rxb_s b;
   logic b_vld;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // one wait state: the data phase acts at the edge after the address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ph_ff <= 1'b0;
         ph_wr_ff <= 1'b0;
         ph_hit_ff <= 1'b0;
         ph_addr_ff <= 8'h00;
         hreadyout_o <= 1'b1;
      end else if (hready_i && hsel_i && htrans_i[1]) begin
         ph_ff <= 1'b1;
         ph_wr_ff <= hwrite_i;
         ph_hit_ff <= (haddr_i[31:8] == 24'h0);
         ph_addr_ff <= haddr_i[7:0];
         hreadyout_o <= 1'b0;
      end else begin
         ph_ff <= 1'b0;
         hreadyout_o <= 1'b1;
      end
   end

   assign wr = ph_ff && ph_wr_ff && ph_hit_ff;

   always_comb begin
      rd_val = 32'h0;
      if (ph_hit_ff) begin
         case (ph_addr_ff)
            `HBSH_A_TXS0: rd_val = {24'h0, txs_ff[0]};
            `HBSH_A_TXS1: rd_val = {24'h0, txs_ff[1]};
            `HBSH_A_RXS0: rd_val = {24'h0, rxs_ff[0]};
            `HBSH_A_RXS1: rd_val = {24'h0, rxs_ff[1]};
            `HBSH_A_CTRL: rd_val = {27'h0, tx_act_ff, ctrl_ff};
            `HBSH_A_SERR: rd_val = {29'h0, serr_ff};
            `HBSH_A_IST: rd_val = {30'h0, ist_ff};
            `HBSH_A_IEN: rd_val = {30'h0, ien_ff};
            default: begin
               if (ph_addr_ff[7:4] == `HBSH_A_TXD) begin
                  rd_val = {txd_ff[{ph_addr_ff[3:2], 2'h3}],
                     txd_ff[{ph_addr_ff[3:2], 2'h2}],
                     txd_ff[{ph_addr_ff[3:2], 2'h1}],
                     txd_ff[{ph_addr_ff[3:2], 2'h0}]};
               end else if (ph_addr_ff[7:4] == `HBSH_A_RXD) begin
                  rd_val = {rxd_ff[{ph_addr_ff[3:2], 2'h3}],
                     rxd_ff[{ph_addr_ff[3:2], 2'h2}],
                     rxd_ff[{ph_addr_ff[3:2], 2'h1}],
                     rxd_ff[{ph_addr_ff[3:2], 2'h0}]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hrdata_o <= 32'h0;
         hresp_o <= 1'b0;
      end else begin
         hresp_o <= 1'b0;
         if (ph_ff && !ph_wr_ff) begin
            hrdata_o <= rd_val;
         end
      end
   end

   // accepted shapes of a transmit status word
   function automatic logic tx_ok(input logic [7:0] v, input logic h);
      logic [3:0] n;
      logic cnt_ok;
      n = v[3:0];
      cnt_ok = (n != 4'h0) && (n <= `HBSH_CNT_MAX);
      if (v[7]) begin
         tx_ok = 1'b0;
      end else if (!h) begin
         tx_ok = cnt_ok && (v[6:4] == 3'h0);
      end else if (v[`HBSH_B_TX_ABT]) begin
         tx_ok = (v[5:0] == 6'h00);
      end else begin
         tx_ok = cnt_ok;
      end
   endfunction

   for (genvar i = 0; i < 2; i++) begin : g_buf
      logic tx_wr;
      logic rx_wr;
      assign tx_wr = wr && (ph_addr_ff == (i == 0 ? `HBSH_A_TXS0 : `HBSH_A_TXS1));
      assign rx_wr = wr && (ph_addr_ff == (i == 0 ? `HBSH_A_RXS0 : `HBSH_A_RXS1));
      assign tx_bad[i] = tx_wr && (txs_ff[i] != 8'h00
         || !tx_ok(hwdata_i[7:0], ctrl_ff[`HBSH_C_HDLC]));
      assign rx_bad[i] = rx_wr && (hwdata_i[7:0] != 8'h00
         || rxs_ff[i] == 8'h00);

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            txs_ff[i] <= `HBSH_RST_STAT;
         end else if (tx_done && tx_sel_ff == 1'(i)) begin
            txs_ff[i] <= 8'h00;
         end else if (tx_wr && !tx_bad[i]) begin
            txs_ff[i] <= hwdata_i[7:0];
         end
      end

      // the device fill wins over a host clear in the same cycle
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            rxs_ff[i] <= `HBSH_RST_STAT;
         end else if (rx_cmp && rx_sel_ff == 1'(i)) begin
            rxs_ff[i] <= rx_stat_new;
         end else if (rx_wr && hwdata_i[7:0] == 8'h00) begin
            rxs_ff[i] <= 8'h00;
         end
      end

      a_tx_bad_err: assert property (tx_bad[i] |=> serr_ff[`HBSH_E_TX])
         else $error("bad transmit status set without error");
      a_rx_bad_err: assert property (rx_bad[i] |=> serr_ff[`HBSH_E_RX])
         else $error("bad receive status clear without error");
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < 16; k++) begin
            txd_ff[k] <= 8'h00;
         end
      end else if (wr && ph_addr_ff[7:4] == `HBSH_A_TXD) begin
         for (int k = 0; k < 4; k++) begin
            txd_ff[{ph_addr_ff[3:2], 2'(k)}] <= hwdata_i[8*k +: 8];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= `HBSH_RST_CTRL;
         tx_act_ff <= 1'b0;
      end else if (wr && ph_addr_ff == `HBSH_A_CTRL) begin
         ctrl_ff <= hwdata_i[3:0];
         tx_act_ff <= tx_act_ff | hwdata_i[4];
      end
   end

   // error and interrupt flags: a new event wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serr_ff <= 3'h0;
      end else begin
         serr_ff <= (serr_ff & ~((wr && ph_addr_ff == `HBSH_A_SERR)
            ? hwdata_i[2:0] : 3'h0)) | {rx_ovr, |rx_bad, |tx_bad};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ist_ff <= 2'h0;
         ien_ff <= 2'h0;
         irq_o <= 1'b0;
      end else begin
         ist_ff <= (ist_ff & ~((wr && ph_addr_ff == `HBSH_A_ICLR)
            ? hwdata_i[1:0] : 2'h0)) | {rx_cmp, tx_done};
         if (wr && ph_addr_ff == `HBSH_A_IEN) begin
            ien_ff <= hwdata_i[1:0];
         end
         irq_o <= |(ist_ff & ien_ff);
      end
   end

   // transmit: buffers are taken in turn, buffer 0 first
   // the done cycle is skipped: the old buffer is only cleared at its end
   assign tx_start = tx_act_ff && !tx_busy && !tx_done
      && txs_ff[tx_sel_ff] != 8'h00;

   hbsh_framer u_framer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(tx_start),
      .hdlc_i(ctrl_ff[`HBSH_C_HDLC]),
      .stat_i(txs_ff[tx_sel_ff]),
      .byte_i(txd_ff[{tx_sel_ff, tx_idx}]),
      .idx_o(tx_idx),
      .busy_o(tx_busy),
      .done_o(tx_done),
      .out_o(tx_o),
      .vld_o(tx_vld_o),
      .rdy_i(tx_rdy_i)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_sel_ff <= 1'b0;
      end else if (tx_done) begin
         tx_sel_ff <= ~tx_sel_ff;
      end
   end

   a_tx_irq: assert property (tx_done |=> ist_ff[`HBSH_I_TX]
      && txs_ff[$past(tx_sel_ff)] == 8'h00)
      else $error("emptied transmit buffer not cleared or flagged");
   a_tx_abort: assert property (tx_start && ctrl_ff[`HBSH_C_HDLC]
      && txs_ff[tx_sel_ff][`HBSH_B_TX_ABT] |=> tx_vld_o && tx_o.abort)
      else $error("abort request did not reach the stream");

   // receive: byte source is the serial sampler or the parallel stream
   hbsh_sampler #(
      .CYC_FAST(CYC_FAST),
      .CYC_MID(CYC_MID),
      .CYC_SLOW(CYC_SLOW)
   ) u_sampler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(ctrl_ff[`HBSH_C_FSK]),
      .baud_i(hbsh_pkg::hbsh_baud_e'(ctrl_ff[3:2])),
      .bit_i(rx_bit_i),
      .byte_o(sm_byte),
      .vld_o(sm_vld)
   );

   always_comb begin
      b = '0;
      b_vld = 1'b0;
      if (ctrl_ff[`HBSH_C_FSK]) begin
         b.data = sm_byte;
         b_vld = sm_vld;
      end else begin
         b.data = rx_i.data;
         b_vld = rx_vld_i;
         if (ctrl_ff[`HBSH_C_HDLC]) begin
            b.first = rx_i.first;
            b.last = rx_i.last;
            b.err = rx_i.err;
         end
      end
   end

   assign rx_start = b_vld && !rx_fill_ff;
   assign rx_ovr = rx_start && rxs_ff[rx_sel_ff] != 8'h00;
   assign rx_take = b_vld && !rx_ovr;
   assign rx_n = rx_cnt_ff + 4'h1;
   assign rx_cmp = rx_take && (rx_n == `HBSH_CNT_MAX || b.last);
   assign rx_stat_new = {b.last, rx_start ? b.first : rx_sof_ff,
      b.err, rx_n};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_fill_ff <= 1'b0;
         rx_cnt_ff <= 4'h0;
         rx_sel_ff <= 1'b0;
         rx_sof_ff <= 1'b0;
      end else if (rx_cmp) begin
         rx_fill_ff <= 1'b0;
         rx_cnt_ff <= 4'h0;
         rx_sel_ff <= ~rx_sel_ff;
         rx_sof_ff <= 1'b0;
      end else if (rx_take) begin
         rx_fill_ff <= 1'b1;
         rx_cnt_ff <= rx_n;
         if (rx_start) begin
            rx_sof_ff <= b.first;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int k = 0; k < 16; k++) begin
            rxd_ff[k] <= 8'h00;
         end
      end else if (rx_take) begin
         rxd_ff[{rx_sel_ff, rx_cnt_ff[2:0]}] <= b.data;
      end
   end

   a_rx_count: assert property (rx_cmp |=>
      rxs_ff[$past(rx_sel_ff)][3:0] inside {[4'h1:4'h8]})
      else $error("receive byte count out of range");
   a_rx_swap: assert property (rx_cmp |=> rx_sel_ff != $past(rx_sel_ff))
      else $error("receive buffers not used in turn");
   a_rx_eof_bit: assert property (rx_cmp && b.last |=>
      rxs_ff[$past(rx_sel_ff)][`HBSH_B_RX_EOF])
      else $error("frame end not reported");
   a_rx_abort_code: assert property (rx_cmp && b.err == `HBSH_ERR_ABORT
      |=> rxs_ff[$past(rx_sel_ff)][5:4] == 2'h3)
      else $error("aborted frame code wrong");
   a_rx_busy_buf: assert property (rx_ovr |=> !rx_fill_ff
      && serr_ff[`HBSH_E_OVR])
      else $error("filled a buffer that was not free");
   a_rx_irq: assert property (rx_cmp |=> ist_ff[`HBSH_I_RX] ##1
      (irq_o || !$past(ien_ff[`HBSH_I_RX])))
      else $error("full receive buffer not signalled");
endmodule

/* File: hbsh_sink.sv */
// transmit stream sink that logs every byte taken and stalls every other cycle
`timescale 1ns/1ps
module hbsh_sink (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // byte stream
   input wire hbsh_pkg::hbsh_txb_s in_i,
   input wire logic vld_i,
   output logic rdy_o
);
   hbsh_pkg::hbsh_txb_s q[$];
   // ready toggles so the framer has to hold each byte through a stall
   always @(posedge clk_i) begin
      if (rst_i) begin
         rdy_o <= 1'b0;
      end else begin
         rdy_o <= ~rdy_o;
         if (vld_i && rdy_o) begin
            q.push_back(in_i);
         end
      end
   end
endmodule

/* File: hbsh_top_tb.sv */
// self-checking testbench of the buffer status handshake block
`timescale 1ns/1ps
`include "hbsh_defs.svh"
module hbsh_top_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic rx_vld = 1'b0;
   logic rx_bit = 1'b1;
   logic hready;
   logic hresp;
   logic tx_vld;
   logic tx_rdy;
   logic irq;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] r;
   hbsh_pkg::hbsh_txb_s tx;
   hbsh_pkg::hbsh_rxb_s rx = '0;
   int err_count = 0;
   int n_tests = 0;
   initial forever #20 clk_i = ~clk_i;
   hbsh_top #(.CYC_FAST(16), .CYC_MID(32), .CYC_SLOW(64)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .tx_o(tx), .tx_vld_o(tx_vld),
      .tx_rdy_i(tx_rdy), .rx_i(rx), .rx_vld_i(rx_vld), .rx_bit_i(rx_bit),
      .irq_o(irq));
   hbsh_sink sink_u (.clk_i(clk_i), .rst_i(rst_i), .in_i(tx),
      .vld_i(tx_vld), .rdy_o(tx_rdy));
   task final_report;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // waits for hready high at a rising edge, bounded
   task wait_ready;
      int i;
      i = 0;
      @(posedge clk_i);
      while (hready !== 1'b1) begin
         @(posedge clk_i);
         i++;
         if (i > 50) begin
            err_count++;
            final_report;
         end
      end
   endtask
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wait_ready;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_ready;
      r = hrdata;
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task rd(input logic [31:0] a);
      ahb(1'b0, a, 32'h0);
   endtask
   // reads until the value shows up or the bound runs out
   task poll(input logic [31:0] a, input logic [31:0] exp);
      int i;
      r = 32'hFFFFFFFF;
      for (i = 0; i < 200 && r !== exp; i++) begin
         rd(a);
      end
      if (r !== exp) begin
         err_count++;
         final_report;
      end
   endtask
   // one serial character: start bit, eight data bits lsb first, stop bit
   task ser(input logic [7:0] v, input int n);
      int i;
      for (i = 0; i < 10; i++) begin
         rx_bit <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : v[i - 1];
         repeat (n) @(posedge clk_i);
      end
   endtask
   task rxs(input hbsh_pkg::hbsh_rxb_s b);
      rx <= b;
      rx_vld <= 1'b1;
      @(posedge clk_i);
   endtask
   task t_reset;
      int i;
      for (i = 0; i < 4; i++) begin
         rd(32'(i * 4));
         chk("status after reset", r, 32'h0);
      end
      rd(`HBSH_A_SERR);
      chk("error after reset", r, 32'h0);
      chk("irq after reset", {31'h0, irq}, 32'h0);
      $display("test reset done");
   endtask
   task t_tx;
      wr(`HBSH_A_IEN, 32'h3);
      wr(`HBSH_A_CTRL, 32'h1);
      wr(32'h40, 32'h332211AA);
      wr(`HBSH_A_TXS0, 32'h33);
      wr(`HBSH_A_CTRL, 32'h11);
      poll(`HBSH_A_TXS0, 32'h0);
      chk("tx0 status cleared", r, 32'h0);
      chk("tx bytes", sink_u.q.size(), 32'h3);
      chk("tx byte0", 32'(sink_u.q[0]), {21'h0, 8'hAA, 3'b100});
      chk("tx byte2", 32'(sink_u.q[2]), {21'h0, 8'h22, 3'b010});
      rd(`HBSH_A_IST);
      chk("tx irq status", r, 32'h1);
      chk("irq line", {31'h0, irq}, 32'h1);
      wr(`HBSH_A_ICLR, 32'h1);
      rd(`HBSH_A_IST);
      chk("irq cleared", {r[31:0]}, 32'h0);
      chk("irq line low", {31'h0, irq}, 32'h0);
      wr(`HBSH_A_TXS1, 32'h40);
      poll(`HBSH_A_TXS1, 32'h0);
      chk("abort item", 32'(sink_u.q[3]), {21'h0, 8'h00, 3'b001});
      $display("test transmit done");
   endtask
   task t_txbad;
      logic [7:0] bad [3];
      int i;
      bad = '{8'h09, 8'h80, 8'h50};
      for (i = 0; i < 3; i++) begin
         wr(`HBSH_A_TXS0, {24'h0, bad[i]});
         rd(`HBSH_A_TXS0);
         chk("bad tx status ignored", r, 32'h0);
         rd(`HBSH_A_SERR);
         chk("tx error set", r, 32'h1);
         wr(`HBSH_A_SERR, 32'h1);
      end
      rd(`HBSH_A_SERR);
      chk("tx error cleared", r, 32'h0);
      $display("test bad transmit status done");
   endtask
   task t_rx;
      wr(`HBSH_A_ICLR, 32'h3);
      rxs('{data: 8'h5A, first: 1'b1, last: 1'b0, err: 2'h0});
      rxs('{data: 8'hA5, first: 1'b0, last: 1'b1, err: 2'h1});
      rx_vld <= 1'b0;
      rd(`HBSH_A_RXS0);
      chk("rx0 status", r, 32'hD2);
      rd(32'h50);
      chk("rx0 data", r & 32'hFFFF, 32'hA55A);
      rd(`HBSH_A_IST);
      chk("rx irq status", r, 32'h2);
      wr(`HBSH_A_RXS0, 32'h0);
      rd(`HBSH_A_RXS0);
      chk("rx0 emptied", r, 32'h0);
      rd(`HBSH_A_SERR);
      chk("proper rx clear", r, 32'h0);
      wr(`HBSH_A_RXS0, 32'h0);
      rd(`HBSH_A_SERR);
      chk("rx clear of empty", r, 32'h2);
      wr(`HBSH_A_SERR, 32'h2);
      rxs('{data: 8'h77, first: 1'b1, last: 1'b1, err: 2'h3});
      rx_vld <= 1'b0;
      rd(`HBSH_A_RXS1);
      chk("rx1 aborted", r, 32'hF1);
      $display("test receive done");
   endtask
   task t_serial;
      logic [7:0] v [8];
      int i;
      v = '{8'h01, 8'h80, 8'hC3, 8'h5A, 8'h3C, 8'hFF, 8'h00, 8'hA5};
      wr(`HBSH_A_CTRL, 32'h2);
      for (i = 0; i < 8; i++) begin
         if (i == 4) begin
            wr(`HBSH_A_CTRL, 32'h6);
         end
         ser(v[i], (i < 4) ? 16 : 32);
      end
      rd(`HBSH_A_RXS0);
      chk("serial rx0 status", r, 32'h8);
      rd(32'h50);
      chk("serial word0", r, 32'h5AC38001);
      rd(32'h54);
      chk("serial word1", r, 32'hA500FF3C);
      rd(`HBSH_A_SERR);
      chk("no serial error", r, 32'h0);
      ser(8'h42, 32);
      rd(`HBSH_A_SERR);
      chk("overrun error", r, 32'h4);
      rd(`HBSH_A_RXS1);
      chk("busy buffer kept", r, 32'hF1);
      $display("test serial receive done");
   endtask
   task t_unmapped;
      wr(32'h30, 32'hFFFFFFFF);
      rd(32'h30);
      chk("unmapped read", r, 32'h0);
      rd(32'h100);
      chk("out of range read", r, 32'h0);
      chk("okay response", {31'h0, hresp}, 32'h0);
      $display("test unmapped done");
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_tx;
      t_txbad;
      t_rx;
      t_serial;
      t_unmapped;
      final_report;
   end
endmodule
